// File: qbs_host.sv
// Controller end: makes the clock pair, issues bursts, gathers read bursts.
// Assumes sys_clk at 200 MHz; the link clock is a divide by four of it.
`timescale 1ns/1ps
`default_nettype none
module qbs_host #(
   parameter int DW = qbs_pkg::DATA_W,
   parameter int AW = qbs_pkg::ADDR_W,
   parameter int SETUP_CYCLES = qbs_pkg::SETUP_CYC
) (
   input  wire logic                             sys_clk,
   input  wire logic                             nrst,
   qbs_if.host                                   lnk,
   input  wire logic                             cmd_valid,
   input  wire logic                             cmd_write,
   input  wire logic [AW-1:0]                    cmd_addr,
   input  wire logic [4*DW-1:0]                  cmd_wdata,
   input  wire logic [4*DW/qbs_pkg::BYTE_W-1:0] cmd_wben_n,
   output logic                                  cmd_ready,
   output logic [4*DW-1:0]                       rd_data,
   output logic                                  rd_valid,
   output logic                                  setup_done,
   input  wire logic                             restart_setup,
   input  wire logic                             clock_stop
);
   import qbs_pkg::*;

   localparam int BW = DW / BYTE_W;
   localparam int SC_W = $clog2(SETUP_CYCLES + 1);

   qbs_hst_t         st_r;
   logic [SC_W-1:0]  sc_r;
   logic [1:0]       cnt_r;
   logic [1:0]       cnt_nxt;
   logic             run_clk;
   logic             slot;
   logic             half_b;
   logic             take;
   logic             rprev_r;
   logic             wprev_r;
   logic             wpend_r;
   logic [1:0]       hs_r;
   logic [1:0]       rd_out_r;
   logic [4*DW-1:0]  wd_r;
   logic [4*BW-1:0]  wb_r;
   logic [3*DW-1:0]  od_r;
   logic [3*BW-1:0]  ob_r;
   logic [DW-1:0]    q_s1_r;
   logic [DW-1:0]    q_s2_r;
   logic [2:0]       v_r;
   logic [2:0]       e_r;
   logic [1:0]       rc_r;
   logic [3*DW-1:0]  rb_r;
   logic             cap;

   // Park only when idle, at K low and /K high
   assign run_clk = !(clock_stop && !wpend_r && hs_r == 2'h0 && rd_out_r == 2'h0)
                    || cnt_r != PH_KLOW;
   assign cnt_nxt = run_clk ? cnt_r + 2'h1 : cnt_r;
   assign slot    = run_clk && cnt_r == PH_KFALL;
   assign half_b  = run_clk && cnt_r == PH_KRISE;
   // No same-type request on consecutive K rises
   assign cmd_ready = st_r == hst_run && slot && !clock_stop
                      && !(cmd_write ? wprev_r : rprev_r);
   assign take = cmd_valid && cmd_ready;
   assign setup_done = st_r == hst_run;
   assign cap = (e_r[2] ^ e_r[1]) && v_r[2];

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r       <= PH_KLOW;
         lnk.k_clk   <= 1'b0;
         lnk.k_n_clk <= 1'b1;
      end else begin
         cnt_r       <= cnt_nxt;
         lnk.k_clk   <= !cnt_nxt[1];
         lnk.k_n_clk <= cnt_nxt[1];
      end
   end

   // Stable-clock NOP setup before any command
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= hst_setup;
         sc_r <= '0;
      end else begin
         case (st_r)
            hst_setup: begin
               if (restart_setup) begin
                  sc_r <= '0;
               end else if (sc_r == SC_W'(SETUP_CYCLES - 1)) begin
                  st_r <= hst_run;
               end else if (run_clk) begin
                  sc_r <= sc_r + SC_W'(1);
               end
            end
            hst_run: begin
               if (restart_setup) begin
                  st_r <= hst_setup;
                  sc_r <= '0;
               end
            end
            default: begin
               st_r <= hst_setup;
               sc_r <= '0;
            end
         endcase
      end
   end

   // Command pins change a quarter K cycle (one sys_clk) before the K rise
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lnk.read_n           <= 1'b1;
         lnk.write_n          <= 1'b1;
         lnk.burst_address_in <= '0;
         lnk.pll_bypass_n     <= PLL_BYPASS_N_LVL;
         rprev_r              <= 1'b0;
         wprev_r              <= 1'b0;
      end else if (slot) begin
         lnk.read_n  <= !(take && !cmd_write);
         lnk.write_n <= !(take && cmd_write);
         rprev_r     <= take && !cmd_write;
         wprev_r     <= take && cmd_write;
         if (take) begin
            lnk.burst_address_in <= cmd_addr;
         end
      end
   end

   // Write words at mid-phase: word 0 before K(t+1), then every half cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wpend_r <= 1'b0;
         hs_r    <= 2'h0;
         wd_r    <= '0;
         wb_r    <= '1;
         od_r    <= '0;
         ob_r    <= '1;
         lnk.d   <= '0;
         lnk.byte_write_enable_n <= '1;
      end else begin
         if (slot && wpend_r) begin
            lnk.d   <= wd_r[DW-1:0];
            lnk.byte_write_enable_n <= wb_r[BW-1:0];
            od_r    <= wd_r[4*DW-1:DW];
            ob_r    <= wb_r[4*BW-1:BW];
            hs_r    <= 2'h3;
         end else if ((slot || half_b) && hs_r != 2'h0) begin
            lnk.d   <= od_r[DW-1:0];
            lnk.byte_write_enable_n <= ob_r[BW-1:0];
            od_r    <= {{DW{1'b0}}, od_r[3*DW-1:DW]};
            ob_r    <= {{BW{1'b1}}, ob_r[3*BW-1:BW]};
            hs_r    <= hs_r - 2'h1;
         end
         if (take && cmd_write) begin
            wd_r    <= cmd_wdata;
            wb_r    <= cmd_wben_n;
            wpend_r <= 1'b1;
         end else if (slot) begin
            wpend_r <= 1'b0;
         end
      end
   end

   // Read returns: q passes two flops, valid and echo three; words taken on echo edges
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q_s1_r <= '0;
         q_s2_r <= '0;
         v_r    <= 3'h0;
         e_r    <= 3'h0;
      end else begin
         q_s1_r <= lnk.q;
         q_s2_r <= q_s1_r;
         v_r    <= {v_r[1], v_r[0], lnk.read_valid_flag};
         e_r    <= {e_r[1], e_r[0], lnk.echo_clock_pos};
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rc_r     <= 2'h0;
         rb_r     <= '0;
         rd_data  <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= cap && rc_r == 2'h3;
         if (cap) begin
            rc_r <= rc_r + 2'h1;
            rb_r <= {q_s2_r, rb_r[3*DW-1:DW]};
            if (rc_r == 2'h3) begin
               rd_data <= {q_s2_r, rb_r};
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_out_r <= 2'h0;
      end else if ((take && !cmd_write) && !rd_valid) begin
         rd_out_r <= rd_out_r + 2'h1;
      end else if (!(take && !cmd_write) && rd_valid) begin
         rd_out_r <= rd_out_r - 2'h1;
      end
   end
endmodule
`default_nettype wire

// File: qbs_pkg.sv
// Constants shared by both ends of the quad-rate burst memory port.
// Assumes nothing beyond a SystemVerilog compiler.
package qbs_pkg;
   localparam int DATA_W = 36;
   localparam int BYTE_W = 9;
   localparam int ADDR_W = 20;
   localparam int OFS_W = 2;
   localparam int BURST = 4;
   localparam logic [1:0] OFS_0 = 2'h0;
   localparam logic [1:0] OFS_1 = 2'h1;
   localparam logic [1:0] OFS_2 = 2'h2;
   localparam logic [1:0] OFS_3 = 2'h3;
   localparam int SYS_MHZ = 200;
   localparam int SETUP_US = 20;
   localparam int SETUP_CYC = SETUP_US * SYS_MHZ;
   localparam int PLL_MIN_MHZ = 250;
   localparam int K_DIV = 4;
   localparam int K_MHZ = SYS_MHZ / K_DIV;
   localparam logic PLL_BYPASS_N_LVL = (K_MHZ >= PLL_MIN_MHZ) ? 1'b1 : 1'b0;
   localparam logic [1:0] PH_KRISE = 2'h0;
   localparam logic [1:0] PH_KFALL = 2'h2;
   localparam logic [1:0] PH_KLOW = 2'h3;
   typedef enum logic [1:0] {
      hst_setup = 2'b01,
      hst_run   = 2'b10
   } qbs_hst_t;
endpackage

// File: qbs_if.sv
// Link between memory controller and burst memory port.
// Assumes the controller end makes both input clocks.
`timescale 1ns/1ps
`default_nettype none
interface qbs_if #(
   parameter int DW = qbs_pkg::DATA_W,
   parameter int AW = qbs_pkg::ADDR_W
);
   localparam int BW = DW / qbs_pkg::BYTE_W;
   logic          k_clk;
   logic          k_n_clk;
   logic          read_n;
   logic          write_n;
   logic [AW-1:0] burst_address_in;
   logic [DW-1:0] d;
   logic [BW-1:0] byte_write_enable_n;
   logic          pll_bypass_n;
   logic [DW-1:0] q;
   logic          q_oe;
   logic          echo_clock_pos;
   logic          echo_clock_neg;
   logic          read_valid_flag;
   modport dev (
      input  k_clk, k_n_clk, read_n, write_n, burst_address_in, d,
      input  byte_write_enable_n, pll_bypass_n,
      output q, q_oe, echo_clock_pos, echo_clock_neg, read_valid_flag
   );
   modport host (
      output k_clk, k_n_clk, read_n, write_n, burst_address_in, d,
      output byte_write_enable_n, pll_bypass_n,
      input  q, q_oe, echo_clock_pos, echo_clock_neg, read_valid_flag
   );
endinterface
`default_nettype wire

// File: qbs_device.sv
// Memory end of the quad-rate burst port: array, burst sequencing, DDR output.
// Assumes both input clocks arrive from the controller roughly 180 degrees apart.
`timescale 1ns/1ps
`default_nettype none
module qbs_device #(
   parameter int DW = qbs_pkg::DATA_W,
   parameter int AW = qbs_pkg::ADDR_W
) (
   qbs_if.dev         lnk,
   input  wire logic  nrst,
   output logic       pll_bypassed
);
   import qbs_pkg::*;

   localparam int BW = DW / BYTE_W;
   localparam int MW = AW + OFS_W;

   logic [DW-1:0] mem [0:(1<<MW)-1];

   logic [3:0]    rd_sh_r;
   logic [2:0]    wr_sh_r;
   logic [AW-1:0] ra0_r;
   logic [AW-1:0] ra1_r;
   logic [AW-1:0] ra2_r;
   logic [AW-1:0] wa0_r;
   logic [AW-1:0] wa1_r;
   logic [DW-1:0] dk_r;
   logic [BW-1:0] bk_r;
   logic [DW-1:0] qk_r;
   logic          oek_r;
   logic [DW-1:0] qkn_r;
   logic          oekn_r;
   logic          vld_r;
   logic          pb_s1_r;
   logic          pb_s2_r;
   logic          rd_go;
   logic          wr_go;

   function automatic logic [MW-1:0] widx(input logic [AW-1:0] a,
                                          input logic [OFS_W-1:0] o);
      return {a, o};
   endfunction

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                           input logic [DW-1:0] new_w,
                                           input logic [BW-1:0] ben_n);
      logic [DW-1:0] res;
      res = old_w;
      for (int b = 0; b < BW; b++) begin
         if (!ben_n[b]) begin
            res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
         end
      end
      return res;
   endfunction

   // A select low just after an accepted one of its kind is ignored
   assign rd_go = !lnk.read_n && !rd_sh_r[0];
   assign wr_go = !lnk.write_n && !wr_sh_r[0] && !rd_go;

   // Burst phase tracking, sampled on K rise only
   always_ff @(posedge lnk.k_clk or negedge nrst) begin
      if (!nrst) begin
         rd_sh_r <= 4'h0;
         wr_sh_r <= 3'h0;
      end else begin
         rd_sh_r <= {rd_sh_r[2:0], rd_go};
         wr_sh_r <= {wr_sh_r[1:0], wr_go};
      end
   end

   // Address pipelines so that bursts may overlap
   always_ff @(posedge lnk.k_clk or negedge nrst) begin
      if (!nrst) begin
         ra0_r <= '0;
         ra1_r <= '0;
         ra2_r <= '0;
      end else begin
         if (rd_go) begin
            ra0_r <= lnk.burst_address_in;
         end
         ra1_r <= ra0_r;
         ra2_r <= ra1_r;
      end
   end

   always_ff @(posedge lnk.k_clk or negedge nrst) begin
      if (!nrst) begin
         wa0_r <= '0;
         wa1_r <= '0;
      end else begin
         if (wr_go) begin
            wa0_r <= lnk.burst_address_in;
         end
         wa1_r <= wa0_r;
      end
   end

   // Even write words and their enables, held for the /K rise
   always_ff @(posedge lnk.k_clk or negedge nrst) begin
      if (!nrst) begin
         dk_r <= '0;
         bk_r <= '1;
      end else begin
         dk_r <= lnk.d;
         bk_r <= lnk.byte_write_enable_n;
      end
   end

   // Array update on /K rise: even word from K rise, odd word live
   always_ff @(posedge lnk.k_n_clk) begin
      if (wr_sh_r[1]) begin
         mem[widx(wa0_r, OFS_0)] <= merge(mem[widx(wa0_r, OFS_0)], dk_r, bk_r);
         mem[widx(wa0_r, OFS_1)] <= merge(mem[widx(wa0_r, OFS_1)], lnk.d,
                                          lnk.byte_write_enable_n);
      end else if (wr_sh_r[2]) begin
         mem[widx(wa1_r, OFS_2)] <= merge(mem[widx(wa1_r, OFS_2)], dk_r, bk_r);
         mem[widx(wa1_r, OFS_3)] <= merge(mem[widx(wa1_r, OFS_3)], lnk.d,
                                          lnk.byte_write_enable_n);
      end
   end

   // Even read words launched on K rise
   always_ff @(posedge lnk.k_clk or negedge nrst) begin
      if (!nrst) begin
         qk_r  <= '0;
         oek_r <= 1'b0;
      end else begin
         if (rd_sh_r[1]) begin
            qk_r  <= mem[widx(ra1_r, OFS_0)];
            oek_r <= 1'b1;
         end else if (rd_sh_r[2]) begin
            qk_r  <= mem[widx(ra2_r, OFS_2)];
            oek_r <= 1'b1;
         end else begin
            oek_r <= 1'b0;
         end
      end
   end

   // Odd read words launched on /K rise
   always_ff @(posedge lnk.k_n_clk or negedge nrst) begin
      if (!nrst) begin
         qkn_r  <= '0;
         oekn_r <= 1'b0;
      end else begin
         if (rd_sh_r[2]) begin
            qkn_r  <= mem[widx(ra2_r, OFS_1)];
            oekn_r <= 1'b1;
         end else if (rd_sh_r[3]) begin
            qkn_r  <= mem[widx(ra2_r, OFS_3)];
            oekn_r <= 1'b1;
         end else begin
            oekn_r <= 1'b0;
         end
      end
   end

   // Valid rises at /K before word 0, falls at /K of word 3
   always_ff @(posedge lnk.k_n_clk or negedge nrst) begin
      if (!nrst) begin
         vld_r <= 1'b0;
      end else begin
         vld_r <= rd_sh_r[1] | rd_sh_r[2];
      end
   end

   // Static mode pin, synchronised into the K domain
   always_ff @(posedge lnk.k_clk or negedge nrst) begin
      if (!nrst) begin
         pb_s1_r      <= 1'b0;
         pb_s2_r      <= 1'b0;
         pll_bypassed <= 1'b1;
      end else begin
         pb_s1_r      <= lnk.pll_bypass_n;
         pb_s2_r      <= pb_s1_r;
         pll_bypassed <= !pb_s2_r;
      end
   end

   // DDR output mux: K-high half shows K word, low half the /K word
   assign lnk.q    = lnk.k_clk ? qk_r : qkn_r;
   assign lnk.q_oe = lnk.k_clk ? oek_r : oekn_r;
   assign lnk.read_valid_flag = vld_r;
   // Echo clocks follow the input pair whether or not reads run
   assign lnk.echo_clock_pos = lnk.k_clk;
   assign lnk.echo_clock_neg = lnk.k_n_clk;
endmodule
`default_nettype wire

// File: qbs_chk.sv
// Link checker for the quad-rate burst memory port.
// Assumes the host end makes both link clocks; watches link wires only.
`timescale 1ns/1ps
`default_nettype none
module qbs_chk #(
   parameter int SETUP_CYCLES = qbs_pkg::SETUP_CYC
) (
   input wire logic nrst,
   input wire logic k_clk,
   input wire logic k_n_clk,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic pll_bypass_n,
   input wire logic q_oe,
   input wire logic echo_clock_pos,
   input wire logic echo_clock_neg,
   input wire logic read_valid_flag
);
   localparam int SETUP_K = SETUP_CYCLES / qbs_pkg::K_DIV - 1;
   logic        rd_prev_r;
   logic [15:0] k_cnt_r;
   logic        rd_acc;
   // Read taken: low select not right after a taken read
   assign rd_acc = !read_n && !rd_prev_r;
   always_ff @(posedge k_clk or negedge nrst) begin
      if (!nrst) begin
         rd_prev_r <= 1'b0;
      end else begin
         rd_prev_r <= rd_acc;
      end
   end
   // K rises since reset, saturating
   always_ff @(posedge k_clk or negedge nrst) begin
      if (!nrst) begin
         k_cnt_r <= 16'h0000;
      end else if (k_cnt_r != 16'hFFFF) begin
         k_cnt_r <= k_cnt_r + 16'h0001;
      end
   end
   sequence s_data_out;
      q_oe ##1 q_oe;
   endsequence
   sequence s_valid_on;
      read_valid_flag ##1 read_valid_flag;
   endsequence
   a_read_latency: assert property (@(posedge k_clk) disable iff (!nrst)
      rd_acc |-> ##3 s_data_out) else $error("read data not driven at t+2");
   a_valid_lead: assert property (@(posedge k_clk) disable iff (!nrst)
      rd_acc |-> ##2 s_valid_on) else $error("valid flag not ahead of read data");
   a_valid_end: assert property (@(posedge k_clk) disable iff (!nrst)
      (k_cnt_r > 16'h0002) && $fell(read_valid_flag) |-> q_oe)
      else $error("valid flag not dropped before last word");
   a_oe_only_read: assert property (@(posedge k_clk) disable iff (!nrst)
      q_oe |-> $past(rd_acc, 3) || $past(rd_acc, 4)) else $error("output without a read");
   a_echo_at_k: assert property (@(posedge k_clk) disable iff (!nrst)
      !echo_clock_pos && echo_clock_neg) else $error("echo clocks not matched at K");
   a_echo_at_kn: assert property (@(posedge k_n_clk) disable iff (!nrst)
      echo_clock_pos && !echo_clock_neg) else $error("echo clocks not matched at /K");
   a_rsel_release: assert property (@(posedge k_clk) disable iff (!nrst)
      !read_n |=> read_n) else $error("read select low on consecutive rises");
   a_wsel_release: assert property (@(posedge k_clk) disable iff (!nrst)
      !write_n |=> write_n) else $error("write select low on consecutive rises");
   a_setup_quiet: assert property (@(posedge k_clk) disable iff (!nrst)
      (int'(k_cnt_r) < SETUP_K) |-> read_n && write_n) else $error("command during setup");
   a_bypass_low: assert property (@(posedge k_clk) disable iff (!nrst)
      !pll_bypass_n) else $error("slow clock without bypass");
endmodule
`default_nettype wire

// File: tb_quad_rate_burst4_sram_port.sv
// Testbench joining controller and memory ends over the link.
// Assumes a 200 MHz system clock; setup shortened through the host parameter.
`timescale 1ns/1ps
`default_nettype none
module tb_quad_rate_burst4_sram_port;
   import qbs_pkg::*;
   localparam int AW = 6;
   localparam int SC = 16;
   localparam int BW4 = 4 * DATA_W / BYTE_W;
   logic                sys_clk;
   logic                nrst;
   logic                cmd_valid;
   logic                cmd_write;
   logic [AW-1:0]       cmd_addr;
   logic [4*DATA_W-1:0] cmd_wdata;
   logic [BW4-1:0]      cmd_wben_n;
   logic                cmd_ready;
   logic [4*DATA_W-1:0] rd_data;
   logic                rd_valid;
   logic                setup_done;
   logic                restart_setup;
   logic                clock_stop;
   logic                pll_bypassed;
   logic [BW4-1:0]      be;
   int                  n_errors;
   int                  checks_done;
   int                  cyc;
   int                  t_take;
   int                  t1;
   qbs_if #(.DW(DATA_W), .AW(AW)) u_qbs_if ();
   qbs_host #(.DW(DATA_W), .AW(AW), .SETUP_CYCLES(SC)) u_qbs_host (
      .sys_clk(sys_clk), .nrst(nrst), .lnk(u_qbs_if.host), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_wben_n(cmd_wben_n), .cmd_ready(cmd_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .setup_done(setup_done), .restart_setup(restart_setup),
      .clock_stop(clock_stop));
   qbs_device #(.DW(DATA_W), .AW(AW)) u_qbs_device (
      .lnk(u_qbs_if.dev), .nrst(nrst), .pll_bypassed(pll_bypassed));
   qbs_chk #(.SETUP_CYCLES(SC)) u_qbs_chk (
      .nrst(nrst), .k_clk(u_qbs_if.k_clk), .k_n_clk(u_qbs_if.k_n_clk),
      .read_n(u_qbs_if.read_n), .write_n(u_qbs_if.write_n),
      .pll_bypass_n(u_qbs_if.pll_bypass_n), .q_oe(u_qbs_if.q_oe),
      .echo_clock_pos(u_qbs_if.echo_clock_pos), .echo_clock_neg(u_qbs_if.echo_clock_neg),
      .read_valid_flag(u_qbs_if.read_valid_flag));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial cyc = 0;
   always @(posedge sys_clk) cyc <= cyc + 1;
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic stop_test();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Word i is {seed, i, fixed tail}, so order slips show
   function automatic logic [4*DATA_W-1:0] mk(input logic [7:0] s);
      for (int i = 0; i < 4; i++) mk[DATA_W*i +: DATA_W] = {s, 8'(i), 20'h5_C3A5};
   endfunction
   function automatic logic [4*DATA_W-1:0] mrg(input logic [4*DATA_W-1:0] o,
                                               input logic [4*DATA_W-1:0] n,
                                               input logic [BW4-1:0] b);
      mrg = o;
      for (int i = 0; i < BW4; i++) if (!b[i]) mrg[BYTE_W*i +: BYTE_W] = n[BYTE_W*i +: BYTE_W];
   endfunction
   // Entered just after a rising edge; leaves cmd_valid high
   task automatic issue(input logic wr, input logic [AW-1:0] a,
                        input logic [4*DATA_W-1:0] wd, input logic [BW4-1:0] b);
      int n;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = wd;
      cmd_wben_n = b;
      cmd_valid = 1'b1;
      n = 0;
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      chk(n < 200, "command not taken");
      @(posedge sys_clk);
      t_take = cyc;
      #1;
   endtask
   task automatic wait_rd(input logic [4*DATA_W-1:0] exp);
      int n;
      cmd_valid = 1'b0;
      n = 0;
      while (rd_valid !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      chk(n < 40, "read burst never completed");
      chk(rd_data === exp, "read data mismatch");
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_setup();
      int n;
      n = 0;
      while (setup_done !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         chk(u_qbs_if.q_oe === 1'b0, "output on during setup");
         n++;
      end
      chk(n < 100, "setup never ended");
      @(posedge sys_clk);
      #1;
   endtask
   initial begin
      #100000;
      n_errors++;
      $display("Error at %0t: run did not finish", $time);
      stop_test();
   end
   initial begin
      n_errors = 0;
      checks_done = 0;
      nrst = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = '0;
      cmd_wdata = '0;
      cmd_wben_n = '1;
      restart_setup = 1'b0;
      clock_stop = 1'b0;
      // Late drop so every reset process sees a real falling edge
      #1;
      nrst = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(u_qbs_if.q_oe === 1'b0, "output on in reset");
      nrst = 1'b1;
      wait_setup();
      chk(pll_bypassed === 1'b1, "bypass not reported");
      issue(1'b1, 6'h05, mk(8'h11), '0);
      t1 = t_take;
      issue(1'b1, 6'h3F, mk(8'h22), '0);
      chk(t_take - t1 >= 8, "writes on consecutive K rises");
      issue(1'b0, 6'h05, '0, '1);
      t1 = t_take;
      issue(1'b1, 6'h0A, mk(8'h33), '0);
      chk(t_take - t1 == 4, "write not right after read");
      wait_rd(mk(8'h11));
      issue(1'b0, 6'h3F, '0, '1);
      t1 = t_take;
      issue(1'b0, 6'h0A, '0, '1);
      chk(t_take - t1 >= 8, "reads on consecutive K rises");
      wait_rd(mk(8'h22));
      wait_rd(mk(8'h33));
      be = 16'hA5C3;
      issue(1'b1, 6'h05, mk(8'h44), be);
      issue(1'b1, 6'h3F, mk(8'h55), '1);
      issue(1'b0, 6'h05, '0, '1);
      wait_rd(mrg(mk(8'h11), mk(8'h44), be));
      issue(1'b0, 6'h3F, '0, '1);
      wait_rd(mk(8'h22));
      clock_stop = 1'b1;
      repeat (20) @(negedge sys_clk);
      chk(u_qbs_if.k_clk === 1'b0 && u_qbs_if.k_n_clk === 1'b1, "clocks not parked");
      repeat (8) @(negedge sys_clk);
      chk(u_qbs_if.k_clk === 1'b0 && cmd_ready === 1'b0, "clock ran while stopped");
      chk(u_qbs_if.q_oe === 1'b0, "output on while stopped");
      @(posedge sys_clk);
      #1;
      clock_stop = 1'b0;
      issue(1'b0, 6'h05, '0, '1);
      wait_rd(mrg(mk(8'h11), mk(8'h44), be));
      restart_setup = 1'b1;
      @(posedge sys_clk);
      #1;
      restart_setup = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(setup_done === 1'b0, "setup not repeated");
      @(posedge sys_clk);
      #1;
      wait_setup();
      issue(1'b1, 6'h0A, mk(8'h66), '0);
      issue(1'b0, 6'h0A, '0, '1);
      wait_rd(mk(8'h66));
      stop_test();
   end
endmodule
`default_nettype wire
